// ===== inc/srio_port_reset_control_defines.vh
`ifndef SRIO_PORT_RESET_CONTROL_DEFINES_VH
`define SRIO_PORT_RESET_CONTROL_DEFINES_VH

// ----------------------------------------
// Register bus
// ----------------------------------------
`define ADDR_W          8
`define DATA_W          32
`define REG_SW_CTRL     8'h00
`define REG_SOFT_RST    8'h04
`define REG_PORT_CTRL   8'h08
`define REG_LINK_MAINT  8'h0c
`define REG_FAULT_CSR   8'h10
`define REG_PORT_INFO   8'h14
`define REG_CNT_BASE    8'h20
`define REG_CNT_LAST    8'h34
`define BIT_SCOPE       0
`define BIT_SOFT_RST    0
`define BIT_DISABLE     0
`define BIT_SEND_RST    0

// ----------------------------------------
// Fault csr fields
// ----------------------------------------
`define F_NOT_INIT      0
`define F_PORT_OK       1
`define F_LINK_FAULT    2
`define F_RX_FAULT      3
`define F_RX_FAULT_SEEN 4
`define F_RX_RETRY      5
`define F_RX_RETRY_SEEN 6
`define F_TX_FAULT      7
`define F_TX_FAULT_SEEN 8
`define F_TX_RETRY      9
`define F_TX_RETRY_SEEN 10
`define FAULT_W         11

// ----------------------------------------
// Counts and widths
// ----------------------------------------
`define ACKID_W         5
`define CNT_W           32
`define NUM_CNT         6
`define CNT_IDX_W       3
`define WORD_W          8
`define SPEED_W         2
`define RST_SYM_NEED    3'h4
`define RST_SYM_W       3
`define RESEND_LAST     5'h0f
`define RESEND_W        5
`define LINK_RST_SYMS   3'h4
`define STAT_RX_NEED    32'h00000007
`define STAT_TX_NEED    32'h0000000f
`define CNT_MAX         32'hffffffff

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS          10
`define TIMEOUT_NS      10000
`define TIMEOUT_CYC     (`TIMEOUT_NS / `CLK_NS)
`define LOCKOUT_NS      100
`define LOCKOUT_CYC     (`LOCKOUT_NS / `CLK_NS)
`define SILENT_NS       1000
`define SILENT_CYC      (`SILENT_NS / `CLK_NS)
`define TMR_W           12

`endif

// ===== rtl/event_counter.v
`timescale 1ns/100ps
`include "srio_port_reset_control_defines.vh"

module event_counter
(
	// Clock and reset
	input  wire              i_core_clk,
	input  wire              i_resetn,
	// Control
	input  wire              i_clear,
	input  wire              i_inc,
	// Value
	output reg  [`CNT_W-1:0] o_count_q
);

	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_count_q <= {`CNT_W{1'b0}};
		else if (i_clear)
			o_count_q <= {`CNT_W{1'b0}};
		else if (i_inc && o_count_q != `CNT_MAX)
			o_count_q <= o_count_q + 32'h1;
	end

endmodule

// ===== rtl/reset_symbol_detector.v
`timescale 1ns/100ps
`include "srio_port_reset_control_defines.vh"

module reset_symbol_detector
(
	// Clock and reset
	input  wire i_core_clk,
	input  wire i_resetn,
	// Received symbols
	input  wire i_sym_valid,
	input  wire i_sym_is_reset,
	input  wire i_clear,
	// Sequence found
	output reg  o_seq_done_q
);

	reg [`RST_SYM_W-1:0] run_q;
	reg [`RST_SYM_W-1:0] run_d;

	always @*
	begin
		run_d = run_q;
		if (i_clear)
			run_d = {`RST_SYM_W{1'b0}};
		else if (i_sym_valid && !i_sym_is_reset)
			run_d = {`RST_SYM_W{1'b0}};
		else if (i_sym_valid)
			run_d = run_q + 3'h1;
		if (run_d == `RST_SYM_NEED)
			run_d = {`RST_SYM_W{1'b0}};
	end

	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			run_q        <= {`RST_SYM_W{1'b0}};
			o_seq_done_q <= 1'b0;
		end
		else
		begin
			run_q        <= run_d;
			// Fourth reset symbol in a row
			o_seq_done_q <= !i_clear && i_sym_valid && i_sym_is_reset &&
				(run_q == `RST_SYM_NEED - 3'h1);
		end
	end

endmodule

// ===== rtl/srio_port_reset_control.v
`timescale 1ns/100ps
`include "srio_port_reset_control_defines.vh"

module srio_port_reset_control
(
	// Clock and reset
	input  wire                i_core_clk,
	input  wire                i_resetn,
	// Pins
	input  wire                i_rst_pin_n,
	input  wire [`SPEED_W-1:0] i_speed_strap,
	// Register port
	input  wire [`ADDR_W-1:0]  i_addr,
	input  wire [`DATA_W-1:0]  i_wdata,
	input  wire                i_wr,
	input  wire                i_rd,
	output reg  [`DATA_W-1:0]  o_rdata_q,
	// Received symbol events
	input  wire                i_sym_valid,
	input  wire                i_sym_is_reset,
	input  wire                i_stat_rx,
	input  wire                i_cs_rx,
	input  wire                i_lreq_rx,
	input  wire                i_lresp_rx,
	input  wire                i_pkt_ack,
	// Transmit events
	input  wire                i_stat_tx,
	input  wire                i_cs_tx,
	input  wire                i_lresp_tx,
	input  wire                i_pkt_tx,
	input  wire                i_accept_sent,
	input  wire                i_cs_enq,
	// Inbound packet
	input  wire                i_pkt_sop,
	input  wire                i_pkt_word,
	input  wire                i_pkt_eop,
	input  wire                i_rx_err,
	// Port state inputs
	input  wire                i_in_retry,
	input  wire                i_in_err,
	input  wire                i_in_resume,
	input  wire                i_out_retry,
	input  wire                i_out_err,
	input  wire                i_rtx_store,
	input  wire                i_rtx_free,
	input  wire                i_lane_sync,
	// Reset outputs
	output reg                 o_hard_reset_q,
	output reg                 o_pll_reset_q,
	output reg  [`SPEED_W-1:0] o_port_speed_q,
	output reg                 o_local_reset_q,
	output reg                 o_link_block_q,
	output reg                 o_clk_run_q,
	// Port outputs
	output reg                 o_pkt_commit_q,
	output reg                 o_pkt_discard_q,
	output reg                 o_err_report_q,
	output reg                 o_dup_lreq_err_q,
	output reg  [`ACKID_W-1:0] o_accept_ackid_q,
	output reg  [`ACKID_W-1:0] o_tx_ackid_q,
	output reg                 o_tx_link_reset_q,
	output reg                 o_tx_lreq_status_q,
	output reg                 o_pkt_timeout_q,
	output reg                 o_lane_tx_en_q
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam IN_OK    = 3'b001;
	localparam IN_RSTOP = 3'b010;
	localparam IN_ESTOP = 3'b100;
	localparam OUT_OK    = 4'b0001;
	localparam OUT_RSTOP = 4'b0010;
	localparam OUT_ESTOP = 4'b0100;
	localparam OUT_FATAL = 4'b1000;
	localparam LN_SILENT = 3'b001;
	localparam LN_SEEK   = 3'b010;
	localparam LN_LINK   = 3'b100;
	localparam [31:0] LOCK_LOAD = `LOCKOUT_CYC;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg                  rp_s1_q, rp_s2_q, st_done_q;
	reg [`SPEED_W-1:0]   st_s1_q, st_s2_q;
	reg                  scope_q, dis_q, dis_d1_q;
	reg [2:0]            in_q;
	reg [3:0]            out_q;
	reg [2:0]            ln_q;
	reg [`TMR_W-1:0]     ln_tmr_q, pto_q, lto_q, lock_q;
	reg [`RESEND_W-1:0]  resend_q;
	reg [2:0]            lrs_q;
	reg                  pkt_act_q, lreq_pend_q;
	reg [`WORD_W-1:0]    words_q;
	reg [`ACKID_W-1:0]   exp_ackid_q, acc_cnt_q, ack_exp_q;
	reg [`ACKID_W:0]     rtx_cnt_q, oq_cnt_q;
	reg [`FAULT_W-1:0]   flt_q;
	wire                 seq_done, hard_evt, lsr_evt, clr, sr_wr, lm_wr;
	wire                 commit, lto_hit;
	wire [`NUM_CNT-1:0]  cnt_inc;
	wire [`CNT_W-1:0]    cnt_val [0:`NUM_CNT-1];

	// Register write decode
	function wr_hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] r;
		begin
			wr_hit = i_wr && (a == r);
		end
	endfunction

	// ----------------------------------------
	// Reset sources
	// ----------------------------------------
	assign sr_wr = wr_hit(i_addr, `REG_SOFT_RST) && i_wdata[`BIT_SOFT_RST];
	assign lm_wr = wr_hit(i_addr, `REG_LINK_MAINT) && i_wdata[`BIT_SEND_RST];
	assign hard_evt = !rp_s2_q || sr_wr || (seq_done && !scope_q);
	assign lsr_evt = (seq_done && scope_q) || (dis_q && !dis_d1_q);
	assign clr = lsr_evt || hard_evt;

	reset_symbol_detector u_detect
	(
		.i_core_clk     (i_core_clk),
		.i_resetn       (i_resetn),
		.i_sym_valid    (i_sym_valid),
		.i_sym_is_reset (i_sym_is_reset),
		.i_clear        (hard_evt),
		.o_seq_done_q   (seq_done)
	);

	// Strap synchroniser, filled while reset is held
	always @(posedge i_core_clk)
	begin
		st_s1_q <= i_speed_strap;
		st_s2_q <= st_s1_q;
	end

	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rp_s1_q         <= 1'b1;
			rp_s2_q         <= 1'b1;
			st_done_q       <= 1'b0;
			o_port_speed_q  <= {`SPEED_W{1'b0}};
			o_hard_reset_q  <= 1'b0;
			o_pll_reset_q   <= 1'b0;
			o_local_reset_q <= 1'b0;
			scope_q         <= 1'b0;
			dis_q           <= 1'b0;
			dis_d1_q        <= 1'b0;
			o_link_block_q  <= 1'b0;
			o_clk_run_q     <= 1'b1;
		end
		else
		begin
			rp_s1_q         <= i_rst_pin_n;
			rp_s2_q         <= rp_s1_q;
			st_done_q       <= !hard_evt;
			if (!st_done_q)
				o_port_speed_q <= st_s2_q;
			o_hard_reset_q  <= hard_evt;
			o_pll_reset_q   <= hard_evt;
			o_local_reset_q <= lsr_evt;
			if (hard_evt)
			begin
				scope_q <= 1'b0;
				dis_q   <= 1'b0;
			end
			else
			begin
				if (wr_hit(i_addr, `REG_SW_CTRL))
					scope_q <= i_wdata[`BIT_SCOPE];
				if (wr_hit(i_addr, `REG_PORT_CTRL))
					dis_q <= i_wdata[`BIT_DISABLE];
			end
			dis_d1_q        <= dis_q;
			o_link_block_q  <= dis_q;
			o_clk_run_q     <= !(dis_q && dis_d1_q);
		end
	end

	// ----------------------------------------
	// Inbound side
	// ----------------------------------------
	assign commit = i_pkt_eop && pkt_act_q && !lsr_evt;

	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			in_q             <= IN_OK;
			pkt_act_q        <= 1'b0;
			words_q          <= {`WORD_W{1'b0}};
			lreq_pend_q      <= 1'b0;
			exp_ackid_q      <= {`ACKID_W{1'b0}};
			acc_cnt_q        <= {`ACKID_W{1'b0}};
			o_accept_ackid_q <= {`ACKID_W{1'b0}};
			o_pkt_commit_q   <= 1'b0;
			o_pkt_discard_q  <= 1'b0;
			o_err_report_q   <= 1'b0;
			o_dup_lreq_err_q <= 1'b0;
		end
		else
		begin
			o_pkt_commit_q   <= commit;
			o_pkt_discard_q  <= lsr_evt && pkt_act_q;
			o_err_report_q   <= i_rx_err && !clr;
			o_dup_lreq_err_q <= i_lreq_rx && lreq_pend_q && !clr;
			if (clr)
			begin
				in_q             <= IN_OK;
				pkt_act_q        <= 1'b0;
				words_q          <= {`WORD_W{1'b0}};
				lreq_pend_q      <= 1'b0;
				exp_ackid_q      <= {`ACKID_W{1'b0}};
				acc_cnt_q        <= {`ACKID_W{1'b0}};
				o_accept_ackid_q <= {`ACKID_W{1'b0}};
			end
			else
			begin
				case (in_q)
				IN_OK:
					if (i_in_err)
						in_q <= IN_ESTOP;
					else if (i_in_retry)
						in_q <= IN_RSTOP;
				IN_RSTOP:
					if (i_in_err)
						in_q <= IN_ESTOP;
					else if (i_in_resume)
						in_q <= IN_OK;
				IN_ESTOP:
					if (i_in_resume)
						in_q <= IN_OK;
				default:
					in_q <= IN_OK;
				endcase
				if (i_pkt_sop)
					pkt_act_q <= 1'b1;
				else if (i_pkt_eop)
					pkt_act_q <= 1'b0;
				if (i_pkt_sop || i_pkt_eop)
					words_q <= {`WORD_W{1'b0}};
				else if (i_pkt_word && pkt_act_q)
					words_q <= words_q + 8'h1;
				if (i_lreq_rx)
					lreq_pend_q <= 1'b1;
				else if (i_lresp_tx)
					lreq_pend_q <= 1'b0;
				if (commit)
					exp_ackid_q <= exp_ackid_q + 5'h1;
				if (commit && !(i_accept_sent && acc_cnt_q != 5'h0))
					acc_cnt_q <= acc_cnt_q + 5'h1;
				else if (!commit && i_accept_sent && acc_cnt_q != 5'h0)
					acc_cnt_q <= acc_cnt_q - 5'h1;
				if (i_accept_sent && acc_cnt_q != 5'h0)
					o_accept_ackid_q <= o_accept_ackid_q + 5'h1;
			end
		end
	end

	// ----------------------------------------
	// Outbound side
	// ----------------------------------------
	assign lto_hit = (out_q == OUT_ESTOP) && (lto_q == `TIMEOUT_CYC - 1);

	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			out_q              <= OUT_OK;
			resend_q           <= {`RESEND_W{1'b0}};
			pto_q              <= {`TMR_W{1'b0}};
			lto_q              <= {`TMR_W{1'b0}};
			lock_q             <= {`TMR_W{1'b0}};
			lrs_q              <= 3'h0;
			oq_cnt_q           <= {(`ACKID_W+1){1'b0}};
			rtx_cnt_q          <= {(`ACKID_W+1){1'b0}};
			ack_exp_q          <= {`ACKID_W{1'b0}};
			o_tx_ackid_q       <= {`ACKID_W{1'b0}};
			o_tx_link_reset_q  <= 1'b0;
			o_tx_lreq_status_q <= 1'b0;
			o_pkt_timeout_q    <= 1'b0;
		end
		else
		begin
			o_tx_link_reset_q  <= !clr && !o_tx_link_reset_q &&
				lrs_q != 3'h0 && lock_q == 12'h0;
			o_tx_lreq_status_q <= !clr && lto_hit;
			o_pkt_timeout_q    <= !clr && pto_q == `TIMEOUT_CYC - 1;
			if (clr)
			begin
				out_q        <= OUT_OK;
				resend_q     <= {`RESEND_W{1'b0}};
				pto_q        <= {`TMR_W{1'b0}};
				lto_q        <= {`TMR_W{1'b0}};
				lock_q       <= {`TMR_W{1'b0}};
				lrs_q        <= 3'h0;
				oq_cnt_q     <= {(`ACKID_W+1){1'b0}};
				rtx_cnt_q    <= {(`ACKID_W+1){1'b0}};
				ack_exp_q    <= {`ACKID_W{1'b0}};
				o_tx_ackid_q <= {`ACKID_W{1'b0}};
			end
			else
			begin
				case (out_q)
				OUT_OK:
					if (i_out_err)
						out_q <= OUT_ESTOP;
					else if (i_out_retry)
						out_q <= OUT_RSTOP;
				OUT_RSTOP:
					if (i_out_err)
						out_q <= OUT_ESTOP;
					else if (i_pkt_ack)
						out_q <= OUT_OK;
				OUT_ESTOP:
					if (i_lresp_rx)
						out_q <= OUT_OK;
					else if (lto_hit && resend_q == `RESEND_LAST)
						out_q <= OUT_FATAL;
				OUT_FATAL:
					out_q <= OUT_FATAL;
				default:
					out_q <= OUT_OK;
				endcase
				if (out_q != OUT_ESTOP || i_lresp_rx || lto_hit)
					lto_q <= {`TMR_W{1'b0}};
				else
					lto_q <= lto_q + 12'h1;
				if (i_lresp_rx)
					resend_q <= {`RESEND_W{1'b0}};
				else if (lto_hit && resend_q != `RESEND_LAST)
					resend_q <= resend_q + 5'h1;
				if (i_pkt_tx)
					o_tx_ackid_q <= o_tx_ackid_q + 5'h1;
				if (i_pkt_ack)
					ack_exp_q <= ack_exp_q + 5'h1;
				if (o_tx_ackid_q == ack_exp_q || i_pkt_ack ||
				    pto_q == `TIMEOUT_CYC - 1)
					pto_q <= {`TMR_W{1'b0}};
				else
					pto_q <= pto_q + 12'h1;
				if (lm_wr)
					lrs_q <= `LINK_RST_SYMS;
				else if (o_tx_link_reset_q)
					lrs_q <= lrs_q - 3'h1;
				if (o_tx_link_reset_q)
					lock_q <= LOCK_LOAD[`TMR_W-1:0];
				else if (lock_q != 12'h0)
					lock_q <= lock_q - 12'h1;
				if (i_cs_enq && !i_cs_tx)
					oq_cnt_q <= oq_cnt_q + 6'h1;
				else if (!i_cs_enq && i_cs_tx && oq_cnt_q != 6'h0)
					oq_cnt_q <= oq_cnt_q - 6'h1;
				if (i_rtx_store && !i_rtx_free)
					rtx_cnt_q <= rtx_cnt_q + 6'h1;
				else if (!i_rtx_store && i_rtx_free && rtx_cnt_q != 6'h0)
					rtx_cnt_q <= rtx_cnt_q - 6'h1;
			end
		end
	end

	// ----------------------------------------
	// Lane init and status flags
	// ----------------------------------------
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ln_q           <= LN_SILENT;
			ln_tmr_q       <= {`TMR_W{1'b0}};
			o_lane_tx_en_q <= 1'b0;
			flt_q          <= {{(`FAULT_W-1){1'b0}}, 1'b1};
		end
		else if (clr)
		begin
			ln_q           <= LN_SILENT;
			ln_tmr_q       <= {`TMR_W{1'b0}};
			o_lane_tx_en_q <= 1'b0;
			flt_q          <= {{(`FAULT_W-1){1'b0}}, 1'b1};
		end
		else
		begin
			case (ln_q)
			LN_SILENT:
				if (ln_tmr_q == `SILENT_CYC - 1)
					ln_q <= LN_SEEK;
			LN_SEEK:
				if (i_lane_sync)
					ln_q <= LN_LINK;
			LN_LINK:
				if (!i_lane_sync)
					ln_q <= LN_SEEK;
			default:
				ln_q <= LN_SILENT;
			endcase
			ln_tmr_q       <= (ln_q == LN_SILENT) ? ln_tmr_q + 12'h1 : 12'h0;
			o_lane_tx_en_q <= !(ln_q == LN_SILENT &&
				ln_tmr_q != `SILENT_CYC - 1);
			if (ln_q == LN_LINK && cnt_val[4] >= `STAT_RX_NEED &&
			    cnt_val[5] >= `STAT_TX_NEED)
			begin
				flt_q[`F_PORT_OK]  <= 1'b1;
				flt_q[`F_NOT_INIT] <= 1'b0;
			end
			else if (ln_q != LN_LINK)
				flt_q[`F_PORT_OK]  <= 1'b0;
			flt_q[`F_LINK_FAULT] <= out_q == OUT_FATAL;
			flt_q[`F_RX_FAULT]   <= in_q == IN_ESTOP;
			flt_q[`F_RX_RETRY]   <= in_q == IN_RSTOP;
			flt_q[`F_TX_FAULT]   <= out_q == OUT_ESTOP || out_q == OUT_FATAL;
			flt_q[`F_TX_RETRY]   <= out_q == OUT_RSTOP;
			// Seen bits: write one to clear, a new event wins
			flt_q[`F_RX_FAULT_SEEN] <= in_q == IN_ESTOP ||
				(flt_q[`F_RX_FAULT_SEEN] && !(wr_hit(i_addr, `REG_FAULT_CSR)
				&& i_wdata[`F_RX_FAULT_SEEN]));
			flt_q[`F_RX_RETRY_SEEN] <= in_q == IN_RSTOP ||
				(flt_q[`F_RX_RETRY_SEEN] && !(wr_hit(i_addr, `REG_FAULT_CSR)
				&& i_wdata[`F_RX_RETRY_SEEN]));
			flt_q[`F_TX_FAULT_SEEN] <= out_q == OUT_ESTOP ||
				(flt_q[`F_TX_FAULT_SEEN] && !(wr_hit(i_addr, `REG_FAULT_CSR)
				&& i_wdata[`F_TX_FAULT_SEEN]));
			flt_q[`F_TX_RETRY_SEEN] <= out_q == OUT_RSTOP ||
				(flt_q[`F_TX_RETRY_SEEN] && !(wr_hit(i_addr, `REG_FAULT_CSR)
				&& i_wdata[`F_TX_RETRY_SEEN]));
		end
	end

	// ----------------------------------------
	// Statistics counters
	// ----------------------------------------
	assign cnt_inc = {i_stat_tx, i_stat_rx, i_cs_tx, i_cs_rx, i_pkt_tx,
		commit};

	genvar g;
	generate
		for (g = 0; g < `NUM_CNT; g = g + 1)
		begin : g_cnt
			event_counter u_cnt
			(
				.i_core_clk (i_core_clk),
				.i_resetn   (i_resetn),
				.i_clear    (clr),
				.i_inc      (cnt_inc[g]),
				.o_count_q  (cnt_val[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_rdata_q <= {`DATA_W{1'b0}};
		else if (!i_rd)
			o_rdata_q <= {`DATA_W{1'b0}};
		else if (i_addr == `REG_SW_CTRL)
			o_rdata_q <= {{(`DATA_W-1){1'b0}}, scope_q};
		else if (i_addr == `REG_PORT_CTRL)
			o_rdata_q <= {{(`DATA_W-1){1'b0}}, dis_q};
		else if (i_addr == `REG_LINK_MAINT)
			o_rdata_q <= {29'h0, lrs_q};
		else if (i_addr == `REG_FAULT_CSR)
			o_rdata_q <= {21'h0, flt_q};
		else if (i_addr == `REG_PORT_INFO)
			o_rdata_q <= {13'h0, rtx_cnt_q, oq_cnt_q, exp_ackid_q,
				o_port_speed_q};
		else if (i_addr >= `REG_CNT_BASE && i_addr <= `REG_CNT_LAST &&
		         i_addr[1:0] == 2'b00)
			o_rdata_q <= cnt_val[i_addr[`CNT_IDX_W+1:2] - 3'h0];
		else
			o_rdata_q <= {`DATA_W{1'b0}};
	end

endmodule

// ===== tb/srio_link_partner.sv
`timescale 1ns/100ps
module srio_link_partner
(
	// Clock
	input  wire i_core_clk,
	// Symbol stream
	output reg  o_sym_valid    = 1'b0,
	output reg  o_sym_is_reset = 1'b0
);
	// ----
	// Reset symbol runs, optional breaking symbol
	// ----
	task send_reset(input int n, input bit brk);
		begin
			repeat (n)
			begin
				@(posedge i_core_clk);
				o_sym_valid    <= 1'b1;
				o_sym_is_reset <= 1'b1;
			end
			if (brk)
			begin
				@(posedge i_core_clk);
				o_sym_is_reset <= 1'b0;
			end
			@(posedge i_core_clk);
			o_sym_valid    <= 1'b0;
			o_sym_is_reset <= ~o_sym_is_reset;
		end
	endtask
endmodule

// ===== tb/srio_port_reset_control_chk.sv
`timescale 1ns/100ps
`include "srio_port_reset_control_defines.vh"
module srio_port_reset_control_chk
(
	// Watched ports
	input wire                i_core_clk,
	input wire                i_resetn,
	input wire                o_local_reset_q,
	input wire                o_hard_reset_q,
	input wire                o_pll_reset_q,
	input wire                o_err_report_q,
	input wire                o_dup_lreq_err_q,
	input wire                o_link_block_q,
	input wire                o_clk_run_q,
	input wire                o_pkt_commit_q,
	input wire                o_pkt_discard_q,
	input wire                o_tx_link_reset_q,
	input wire [`ACKID_W-1:0] o_tx_ackid_q
);
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	chk_lsr_pulse:
	assert property (o_local_reset_q |=> !o_local_reset_q)
		else $error("local reset too long");
	chk_err_quiet:
	assert property (o_local_reset_q |-> !o_err_report_q)
		else $error("error reported in reset cycle");
	chk_dup_quiet:
	assert property (o_local_reset_q |-> !o_dup_lreq_err_q)
		else $error("duplicate request reported in reset cycle");
	chk_ackid_zero:
	assert property (o_local_reset_q |-> ##[0:1] (o_tx_ackid_q == 5'h00))
		else $error("tx ackid not cleared");
	chk_disable_seq:
	assert property ($rose(o_link_block_q) |-> o_local_reset_q ##1 !o_clk_run_q)
		else $error("disable order wrong");
	chk_discard_lsr:
	assert property (o_pkt_discard_q |-> o_local_reset_q)
		else $error("discard without local reset");
	chk_no_commit:
	assert property (o_local_reset_q |-> !o_pkt_commit_q)
		else $error("commit in reset cycle");
	chk_pll_hard:
	assert property (o_hard_reset_q |-> o_pll_reset_q)
		else $error("pll reset missing");
	chk_lockout_gap:
	assert property (o_tx_link_reset_q |=> !o_tx_link_reset_q [*8])
		else $error("link reset gap short");
endmodule

bind srio_port_reset_control srio_port_reset_control_chk chk
(
	.i_core_clk(i_core_clk), .i_resetn(i_resetn),
	.o_local_reset_q(o_local_reset_q), .o_hard_reset_q(o_hard_reset_q),
	.o_pll_reset_q(o_pll_reset_q), .o_err_report_q(o_err_report_q),
	.o_dup_lreq_err_q(o_dup_lreq_err_q),
	.o_link_block_q(o_link_block_q), .o_clk_run_q(o_clk_run_q),
	.o_pkt_commit_q(o_pkt_commit_q), .o_pkt_discard_q(o_pkt_discard_q),
	.o_tx_link_reset_q(o_tx_link_reset_q), .o_tx_ackid_q(o_tx_ackid_q)
);

// ===== tb/srio_port_reset_control_tb.sv
`timescale 1ns/100ps
`include "srio_port_reset_control_defines.vh"
module srio_port_reset_control_tb;
	// ----
	// Signals
	// ----
	logic                i_core_clk;
	logic                i_resetn      = 1'b0;
	logic                i_rst_pin_n   = 1'b1;
	logic [`SPEED_W-1:0] i_speed_strap = 2'h2;
	logic [`ADDR_W-1:0]  i_addr        = 8'h00;
	logic [`DATA_W-1:0]  i_wdata       = 32'h0;
	logic                i_wr          = 1'b0;
	logic                i_rd          = 1'b0;
	logic [22:0]         ev            = 23'h0;
	wire  [`DATA_W-1:0]  rdata;
	wire  [`SPEED_W-1:0] speed;
	wire  [`ACKID_W-1:0] ackid;
	wire                 sym_v;
	wire                 sym_r;
	wire                 lsr;
	wire                 hrd;
	wire                 run;
	wire                 disc;
	wire                 tlr;
	wire                 lane_en;
	wire                 lrq;
	wire                 pto;
	int                  bad_count, total_checks, lsr_n, hrd_n, tlr_n;
	int                  disc_n, cyc, lrq_n, pto_n;
	logic [7:0]          ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
		8'h14, 8'h20, 8'h34, 8'h40, 8'h12};
	logic [31:0]         rv [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1,
		32'h2, 32'h0, 32'h0, 32'h0, 32'h0};

	srio_link_partner link
	(
		.i_core_clk(i_core_clk), .o_sym_valid(sym_v), .o_sym_is_reset(sym_r)
	);
	srio_port_reset_control uut
	(
		.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_rst_pin_n(i_rst_pin_n), .i_speed_strap(i_speed_strap),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata_q(rdata), .i_sym_valid(sym_v), .i_sym_is_reset(sym_r),
		.i_stat_rx(ev[0]), .i_cs_rx(ev[1]), .i_lreq_rx(ev[2]),
		.i_lresp_rx(ev[3]), .i_pkt_ack(ev[4]), .i_stat_tx(ev[5]),
		.i_cs_tx(ev[6]), .i_lresp_tx(ev[7]), .i_pkt_tx(ev[8]),
		.i_accept_sent(ev[9]), .i_cs_enq(ev[10]), .i_pkt_sop(ev[11]),
		.i_pkt_word(ev[12]), .i_pkt_eop(ev[13]), .i_rx_err(ev[14]),
		.i_in_retry(ev[15]), .i_in_err(ev[16]), .i_in_resume(ev[17]),
		.i_out_retry(ev[18]), .i_out_err(ev[19]), .i_rtx_store(ev[20]),
		.i_rtx_free(ev[21]), .i_lane_sync(ev[22]),
		.o_hard_reset_q(hrd), .o_pll_reset_q(), .o_port_speed_q(speed),
		.o_local_reset_q(lsr), .o_link_block_q(), .o_clk_run_q(run),
		.o_pkt_commit_q(), .o_pkt_discard_q(disc), .o_err_report_q(),
		.o_dup_lreq_err_q(), .o_accept_ackid_q(), .o_tx_ackid_q(ackid),
		.o_tx_link_reset_q(tlr), .o_tx_lreq_status_q(lrq),
		.o_pkt_timeout_q(pto), .o_lane_tx_en_q(lane_en)
	);

	// ----
	// Clock, pulse counters, timeout
	// ----
	initial
	begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk)
	begin
		cyc    <= cyc + 1;
		lsr_n  <= lsr_n + (lsr === 1'b1);
		hrd_n  <= hrd_n + (hrd === 1'b1);
		tlr_n  <= tlr_n + (tlr === 1'b1);
		disc_n <= disc_n + (disc === 1'b1);
		lrq_n  <= lrq_n + (lrq === 1'b1);
		pto_n  <= pto_n + (pto === 1'b1);
		if (cyc == 4000)
		begin
			bad_count++;
			final_report();
		end
	end

	// ----
	// Tasks
	// ----
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			total_checks++;
			if (got !== exp)
			begin
				bad_count++;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task idle(input int n);
		begin
			repeat (n) @(posedge i_core_clk);
			#1;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge i_core_clk);
			i_addr  <= a;
			i_wdata <= d;
			i_wr    <= 1'b1;
			@(posedge i_core_clk);
			i_wr    <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		begin
			@(posedge i_core_clk);
			i_addr <= a;
			i_rd   <= 1'b1;
			@(posedge i_core_clk);
			i_rd   <= 1'b0;
			#1 chk(rdata, exp);
		end
	endtask
	task final_report();
		begin
			$display("checks %0d bad %0d", total_checks, bad_count);
			if (bad_count == 0 && total_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask

	// ----
	// Sequence
	// ----
	initial
	begin
		repeat (16) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		for (int k = 0; k < 10; k++)
			rd(ra[k], rv[k]);
		$display("defaults done");
		wr(8'h00, 32'h1);
		ev <= 23'h5ddfe7;
		idle(3);
		ev <= 23'h004004;
		link.send_reset(3, 1'b1);
		link.send_reset(4, 1'b0);
		idle(1);
		ev <= 23'h0;
		idle(4);
		chk(lsr_n, 1);
		chk(hrd_n, 0);
		chk(disc_n, 1);
		chk(ackid, 5'h00);
		rd(8'h10, 32'h1);
		rd(8'h24, 32'h0);
		rd(8'h30, 32'h0);
		rd(8'h14, 32'h2);
		rd(8'h00, 32'h1);
		$display("port reset done");
		wr(8'h0c, 32'h1);
		idle(60);
		chk(tlr_n, 4);
		idle(40);
		chk(lane_en, 1'b1);
		wr(8'h08, 32'h1);
		idle(3);
		chk(lsr_n, 2);
		chk(run, 1'b0);
		chk(lane_en, 1'b0);
		rd(8'h08, 32'h1);
		wr(8'h08, 32'h0);
		idle(3);
		chk(run, 1'b1);
		$display("disable done");
		wr(8'h00, 32'h0);
		link.send_reset(4, 1'b0);
		idle(4);
		chk(hrd_n, 1);
		chk(lsr_n, 2);
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h1);
		idle(3);
		chk(hrd_n, 2);
		rd(8'h00, 32'h0);
		i_speed_strap <= 2'h1;
		idle(5);
		i_rst_pin_n <= 1'b0;
		idle(4);
		i_rst_pin_n <= 1'b1;
		idle(8);
		chk(hrd_n > 2, 1);
		chk(speed, 2'h1);
		$display("hard reset done");
		ev <= 23'h080100;
		idle(1);
		ev <= 23'h0;
		idle(1005);
		chk(pto_n, 1);
		chk(lrq_n, 1);
		wr(8'h08, 32'h1);
		wr(8'h08, 32'h0);
		idle(1000);
		chk(pto_n, 1);
		chk(lrq_n, 1);
		$display("timeout done");
		final_report();
	end
endmodule
